/* rtl/potential_transformer_watch.sv */
// potential transformer watch: supervision of vt secondary and fuses
`timescale 1ns/100ps
module potential_transformer_watch #(
  parameter int UPDATE_CYCLES = pt_watch_pkg::UPDATE_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  // measurements, same clock domain
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    mag_a,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    mag_b,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    mag_c,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    mag_d,
  input  wire logic [pt_watch_pkg::ANG_W-1:0]    ang_a,
  input  wire logic [pt_watch_pkg::ANG_W-1:0]    ang_b,
  input  wire logic [pt_watch_pkg::ANG_W-1:0]    ang_c,
  input  wire logic [pt_watch_pkg::ANG_W-1:0]    ang_d,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    pos_seq,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    neg_seq,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    zero_seq,
  // asynchronous pins
  input  wire logic                              bus_breaker_trip_input,
  input  wire logic                              line_breaker_trip_input,
  input  wire logic                              block_input,
  // group settings
  input  wire logic                              settings_load,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    low_pickup_set,
  input  wire logic [pt_watch_pkg::MAG_W-1:0]    high_detect_set,
  input  wire logic [pt_watch_pkg::ASL_W-1:0]    angle_shift_set,
  input  wire logic [pt_watch_pkg::DLY_W-1:0]    operate_delay_set,
  input  wire logic                              bus_fuse_check_set,
  input  wire logic                              line_fuse_check_set,
  // static settings
  input  wire logic                              allow_individual_mode,
  input  wire logic                              mode_load,
  input  wire logic [2:0]                        mode_set,
  input  wire logic                              stage_forcing_enable,
  input  wire logic                              force_load,
  input  wire logic [2:0]                        force_set,
  // results
  output logic                                   update_pulse,
  output logic [2:0]                             node_operating_mode,
  output logic [2:0]                             status_q,
  output logic [2:0]                             bus_state_q,
  output logic                                   start_q,
  output logic                                   alarm_q,
  output logic                                   blocked_q,
  output logic                                   bus_side_failure,
  output logic                                   line_side_failure,
  output logic                                   test_active,
  output logic [2:0][pt_watch_pkg::RATIO_W-1:0]  ratio_low_q,
  output logic [2:0][pt_watch_pkg::RATIO_W-1:0]  ratio_high_q
);
  localparam int TW = $clog2(UPDATE_CYCLES);
  localparam int MW = pt_watch_pkg::MAG_W;
  localparam int AW = pt_watch_pkg::ANG_W;
  localparam int RW = pt_watch_pkg::RATIO_W;
  localparam int HD = pt_watch_pkg::HIST_DEPTH;
  localparam logic [TW-1:0] TICK_LAST = TW'(UPDATE_CYCLES - 1);
  localparam logic [3:0]    FILL_FULL = 4'(HD);

  logic [TW-1:0]               tick_cnt_q;
  logic                        tick;
  logic [2:0]                  meta_q;
  logic [2:0]                  sync_q;
  logic [MW-1:0]               low_q;
  logic [MW-1:0]               high_q;
  logic [pt_watch_pkg::ASL_W-1:0] asl_q;
  logic [pt_watch_pkg::DLY_W-1:0] dly_q;
  logic                        bus_chk_q;
  logic                        line_chk_q;
  pt_watch_pkg::mode_e         mode_q;
  pt_watch_pkg::mode_e         mode_eff;
  pt_watch_pkg::status_e       force_q;
  pt_watch_pkg::sup_state_e    sup_q;
  pt_watch_pkg::status_e       status_d;
  pt_watch_pkg::bus_state_e    bus_d;
  logic [3:0][MW-1:0]          mag_in;
  logic [3:0][AW-1:0]          ang_in;
  logic [3:0][MW-1:0]          mag_q;
  logic [AW-1:0]               hist_q [4][HD];
  logic [3:0]                  fill_q;
  logic [3:0]                  shift_small;
  logic [2:0]                  below_low;
  logic [2:0]                  above_high;
  logic                        low_any;
  logic                        high_two;
  logic                        pickup;
  logic                        angle_block;
  logic                        blk;
  logic                        op_off;
  logic                        dead;
  logic [pt_watch_pkg::DLY_W-1:0] timer_q;
  logic                        bus_fuse_q;
  logic                        line_fuse_q;

  assign mag_in = {mag_d, mag_c, mag_b, mag_a};
  assign ang_in = {ang_d, ang_c, ang_b, ang_a};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == TICK_LAST);
  assign update_pulse = tick;

  // trip and block pins cross into sys_clk through two flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {block_input, line_breaker_trip_input,
                 bus_breaker_trip_input};
      sync_q <= meta_q;
    end
  end

  // group settings may be reloaded at any time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_q      <= pt_watch_pkg::LOW_RST;
      high_q     <= pt_watch_pkg::HIGH_RST;
      asl_q      <= pt_watch_pkg::ASL_RST;
      dly_q      <= pt_watch_pkg::DLY_RST;
      bus_chk_q  <= 1'b1;
      line_chk_q <= 1'b1;
    end else if (settings_load) begin
      if (low_pickup_set < pt_watch_pkg::LOW_MIN) begin
        low_q <= pt_watch_pkg::LOW_MIN;
      end else if (low_pickup_set > pt_watch_pkg::LOW_MAX) begin
        low_q <= pt_watch_pkg::LOW_MAX;
      end else begin
        low_q <= low_pickup_set;
      end
      if (high_detect_set < pt_watch_pkg::HIGH_MIN) begin
        high_q <= pt_watch_pkg::HIGH_MIN;
      end else if (high_detect_set > pt_watch_pkg::HIGH_MAX) begin
        high_q <= pt_watch_pkg::HIGH_MAX;
      end else begin
        high_q <= high_detect_set;
      end
      if (angle_shift_set < pt_watch_pkg::ASL_MIN) begin
        asl_q <= pt_watch_pkg::ASL_MIN;
      end else if (angle_shift_set > pt_watch_pkg::ASL_MAX) begin
        asl_q <= pt_watch_pkg::ASL_MAX;
      end else begin
        asl_q <= angle_shift_set;
      end
      dly_q      <= operate_delay_set;
      bus_chk_q  <= bus_fuse_check_set;
      line_chk_q <= line_fuse_check_set;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q  <= pt_watch_pkg::MODE_ON;
      force_q <= pt_watch_pkg::ST_NORMAL;
    end else begin
      // mode only taken while individual mode allowed
      if (mode_load && allow_individual_mode &&
          mode_set <= 3'(pt_watch_pkg::MODE_OFF)) begin
        mode_q <= pt_watch_pkg::mode_e'(mode_set);
      end
      // force value only taken while forcing enabled
      if (force_load && stage_forcing_enable &&
          force_set <= 3'(pt_watch_pkg::ST_BLOCKED)) begin
        force_q <= pt_watch_pkg::status_e'(force_set);
      end
    end
  end
  // without the permission the node runs as On
  assign mode_eff = allow_individual_mode ? mode_q
                                          : pt_watch_pkg::MODE_ON;
  assign node_operating_mode = 3'(mode_eff);
  assign op_off = (mode_eff == pt_watch_pkg::MODE_OFF);
  assign test_active = (mode_eff == pt_watch_pkg::MODE_TEST) ||
                       (mode_eff == pt_watch_pkg::MODE_TEST_BLOCKED);
  // block level as seen at the start of the cycle
  assign blk = sync_q[2] ||
               (mode_eff == pt_watch_pkg::MODE_BLOCKED) ||
               (mode_eff == pt_watch_pkg::MODE_TEST_BLOCKED);

  // angle history over 40 ms per channel
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mag_q  <= '0;
      fill_q <= pt_watch_pkg::FILL_RST;
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < HD; k++) begin
          hist_q[c][k] <= '0;
        end
      end
    end else if (tick) begin
      mag_q <= mag_in;
      if (fill_q != FILL_FULL) begin
        fill_q <= fill_q + 4'h1;
      end
      for (int c = 0; c < 4; c++) begin
        hist_q[c][0] <= ang_in[c];
        for (int k = 1; k < HD; k++) begin
          hist_q[c][k] <= hist_q[c][k-1];
        end
      end
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_ang
    logic [AW-1:0] diff;
    logic [AW-1:0] wrap;
    always_comb begin
      diff = (hist_q[c][0] >= hist_q[c][HD-1]) ?
             AW'(hist_q[c][0] - hist_q[c][HD-1]) :
             AW'(hist_q[c][HD-1] - hist_q[c][0]);
      wrap = (diff > pt_watch_pkg::ANG_HALF) ?
             AW'(pt_watch_pkg::ANG_FULL - diff) : diff;
    end
    assign shift_small[c] = ({2'b00, asl_q} > wrap);
  end
  // until 40 ms of history exists the shift counts as small
  assign angle_block = (&shift_small) || (fill_q != FILL_FULL);

  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign below_low[p]  = (mag_q[p] < low_q);
    assign above_high[p] = (mag_q[p] > high_q);
    // threshold to magnitude ratio, 8 fraction bits
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        ratio_low_q[p]  <= '0;
        ratio_high_q[p] <= '0;
      end else if (tick) begin
        if (mag_in[p] == '0) begin
          ratio_low_q[p]  <= pt_watch_pkg::RATIO_MAX;
          ratio_high_q[p] <= pt_watch_pkg::RATIO_MAX;
        end else begin
          ratio_low_q[p]  <= RW'({low_q, 8'h00} / mag_in[p]);
          ratio_high_q[p] <= RW'({high_q, 8'h00} / mag_in[p]);
        end
      end
    end
  end

  // any phase under the low pick-up
  assign low_any  = |below_low;
  // at least two phases over high detect
  assign high_two = (above_high[0] & above_high[1]) |
                    (above_high[0] & above_high[2]) |
                    (above_high[1] & above_high[2]);
  assign pickup   = (low_any | high_two) & ~angle_block;
  assign dead     = (&below_low) & (mag_q[3] < low_q);

  // definite time from start to alarm
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sup_q   <= pt_watch_pkg::SUP_IDLE;
      timer_q <= '0;
    end else if (tick) begin
      // evaluation uses the previous update's magnitudes
      case (sup_q)
        pt_watch_pkg::SUP_IDLE: begin
          timer_q <= '0;
          if (pickup && !op_off) begin
            sup_q <= blk ? pt_watch_pkg::SUP_BLOCKED
                         : pt_watch_pkg::SUP_TIMING;
          end
        end
        pt_watch_pkg::SUP_TIMING: begin
          if (!pickup || op_off) begin
            sup_q <= pt_watch_pkg::SUP_IDLE;
          end else if (blk) begin
            // a late block drops the start into the blocked state, not back to idle
            sup_q <= pt_watch_pkg::SUP_BLOCKED;
          end else if (timer_q + 1'b1 >= dly_q) begin
            sup_q <= pt_watch_pkg::SUP_ALARM;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        pt_watch_pkg::SUP_ALARM: begin
          if (!pickup || op_off || blk) begin
            sup_q <= pt_watch_pkg::SUP_IDLE;
          end
        end
        pt_watch_pkg::SUP_BLOCKED: begin
          // held until the pick-up condition resets or the mode goes Off
          if (!pickup || op_off) begin
            sup_q <= pt_watch_pkg::SUP_IDLE;
          end
        end
        default: sup_q <= pt_watch_pkg::SUP_IDLE;
      endcase
    end
  end

  // fuse trips follow the update base, like the voltages
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_fuse_q  <= 1'b0;
      line_fuse_q <= 1'b0;
    end else if (tick) begin
      bus_fuse_q  <= bus_chk_q & sync_q[0] & ~op_off;
      line_fuse_q <= line_chk_q & sync_q[1] & ~op_off;
    end
  end
  assign bus_side_failure  = bus_fuse_q | alarm_q;
  assign line_side_failure = line_fuse_q;

  always_comb begin
    status_d = pt_watch_pkg::ST_NORMAL;
    if (sup_q == pt_watch_pkg::SUP_BLOCKED) begin
      status_d = pt_watch_pkg::ST_BLOCKED;
    end else if (sup_q == pt_watch_pkg::SUP_ALARM || bus_fuse_q) begin
      status_d = pt_watch_pkg::ST_BUS_FAIL;
    end else if (line_fuse_q) begin
      status_d = pt_watch_pkg::ST_LINE_FAIL;
    end else if (sup_q == pt_watch_pkg::SUP_TIMING) begin
      status_d = pt_watch_pkg::ST_START;
    end
    // forced value overrides while forcing enabled
    if (stage_forcing_enable) begin
      status_d = force_q;
    end
  end

  always_comb begin
    bus_d = pt_watch_pkg::BUS_SEQ_UNDEF;
    if (dead) begin
      bus_d = pt_watch_pkg::BUS_DEAD;
    end else if (pickup) begin
      bus_d = pt_watch_pkg::BUS_PROBLEM;
    // sequence decides ok, reversed or undefined
    end else if (zero_seq >= pos_seq && zero_seq >= neg_seq) begin
      bus_d = pt_watch_pkg::BUS_SEQ_UNDEF;
    end else if (pos_seq > neg_seq) begin
      bus_d = pt_watch_pkg::BUS_SEQ_OK;
    end else if (neg_seq > pos_seq) begin
      bus_d = pt_watch_pkg::BUS_SEQ_REV;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q    <= 3'(pt_watch_pkg::ST_NORMAL);
      bus_state_q <= 3'(pt_watch_pkg::BUS_DEAD);
      start_q     <= 1'b0;
      alarm_q     <= 1'b0;
      blocked_q   <= 1'b0;
    end else if (tick) begin
      status_q    <= 3'(status_d);
      bus_state_q <= 3'(bus_d);
      start_q     <= (sup_q == pt_watch_pkg::SUP_TIMING);
      alarm_q     <= (sup_q == pt_watch_pkg::SUP_ALARM);
      blocked_q   <= (sup_q == pt_watch_pkg::SUP_BLOCKED);
    end
  end
endmodule

/* rtl/pt_watch_pkg.sv */
// constants and types of the potential transformer watch
package pt_watch_pkg;
  localparam int CLK_HZ            = 250_000_000;
  localparam int UPDATE_MS         = 5;
  localparam int UPDATE_CYCLES_DEF = CLK_HZ / 1000 * UPDATE_MS;
  localparam int HISTORY_MS        = 40;
  localparam int HIST_DEPTH        = HISTORY_MS / UPDATE_MS;
  localparam int MAG_W             = 8;
  localparam int ANG_W             = 12;
  localparam int ASL_W             = 10;
  localparam int RATIO_W           = 16;
  localparam int DLY_W             = 19;
  // angles in 0.1 degree, magnitudes in 0.01 of nominal_voltage
  localparam logic [ANG_W-1:0]   ANG_FULL  = 12'he10;
  localparam logic [ANG_W-1:0]   ANG_HALF  = 12'h708;
  localparam logic [MAG_W-1:0]   LOW_MIN   = 8'h05;
  localparam logic [MAG_W-1:0]   LOW_MAX   = 8'h32;
  localparam logic [MAG_W-1:0]   LOW_RST   = 8'h05;
  localparam logic [MAG_W-1:0]   HIGH_MIN  = 8'h01;
  localparam logic [MAG_W-1:0]   HIGH_MAX  = 8'h6e;
  localparam logic [MAG_W-1:0]   HIGH_RST  = 8'h50;
  localparam logic [ASL_W-1:0]   ASL_MIN   = 10'h014;
  localparam logic [ASL_W-1:0]   ASL_MAX   = 10'h384;
  localparam logic [ASL_W-1:0]   ASL_RST   = 10'h032;
  localparam logic [DLY_W-1:0]   DLY_RST   = 19'h00014;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 16'hffff;
  localparam int                 RATIO_FRAC = 8;
  localparam logic [3:0]         FILL_RST  = 4'h0;

  typedef enum logic [2:0] {
    MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
  } mode_e;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_START, ST_LINE_FAIL, ST_BUS_FAIL, ST_BLOCKED
  } status_e;
  typedef enum logic [2:0] {
    BUS_DEAD, BUS_SEQ_OK, BUS_SEQ_REV, BUS_SEQ_UNDEF, BUS_PROBLEM
  } bus_state_e;
  typedef enum logic [1:0] {
    SUP_IDLE, SUP_TIMING, SUP_ALARM, SUP_BLOCKED
  } sup_state_e;
endpackage

/* testbench/pt_watch_asserts.sv */
// port checker of the potential transformer watch
`timescale 1ns/100ps
module pt_watch_asserts #(
  parameter int UPDATE_CYCLES = pt_watch_pkg::UPDATE_CYCLES_DEF
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // mode controls
  input wire logic       allow_individual_mode,
  input wire logic       mode_load,
  input wire logic [2:0] mode_set,
  // results
  input wire logic       update_pulse,
  input wire logic [2:0] node_operating_mode,
  input wire logic [2:0] status_q,
  input wire logic [2:0] bus_state_q,
  input wire logic       start_q,
  input wire logic       alarm_q,
  input wire logic       blocked_q,
  input wire logic       bus_side_failure,
  input wire logic       test_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [31:0] gap_q;
  logic        seen_q;
  // the first pulse after reset is skipped: its distance is not a period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else if (update_pulse) begin
      gap_q  <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  upd_period_a: assert property (
    update_pulse && seen_q |-> gap_q == UPDATE_CYCLES - 1)
    else $error("update period wrong");
  upd_single_a: assert property (
    update_pulse |=> !update_pulse [*8])
    else $error("update pulse too long");
  results_stand_a: assert property (
    !update_pulse |=>
      $stable({status_q, bus_state_q, start_q, alarm_q, blocked_q}))
    else $error("result changed between updates");
  alarm_bus_a: assert property (
    alarm_q |-> bus_side_failure)
    else $error("alarm not on bus failure");
  alarm_start_a: assert property (
    $rose(alarm_q) |-> $past(start_q))
    else $error("alarm without start");
  block_excl_a: assert property (
    blocked_q |-> !start_q)
    else $error("start while blocked");
  test_flag_a: assert property (
    test_active == (node_operating_mode inside {3'h2, 3'h3}))
    else $error("test flag wrong");
  mode_gate_a: assert property (
    !allow_individual_mode |-> node_operating_mode == 3'h0)
    else $error("mode not On while not allowed");
  mode_take_a: assert property (
    allow_individual_mode && mode_load && mode_set <= 3'h4
      ##1 allow_individual_mode |-> node_operating_mode == $past(mode_set))
    else $error("mode load not taken");
  mode_hold_a: assert property (
    !mode_load ##1 allow_individual_mode && $past(allow_individual_mode)
      |-> $stable(node_operating_mode))
    else $error("mode changed without load");
  cover property ($rose(alarm_q));
  cover property ($rose(blocked_q));
  cover property (bus_state_q == 3'h0 ##1 bus_state_q == 3'h0);
  cover property (node_operating_mode == 3'h4 && alarm_q);
endmodule
bind potential_transformer_watch pt_watch_asserts #(
  .UPDATE_CYCLES(UPDATE_CYCLES)
) u_chk (
  .sys_clk, .rst, .allow_individual_mode, .mode_load, .mode_set,
  .update_pulse, .node_operating_mode, .status_q, .bus_state_q,
  .start_q, .alarm_q, .blocked_q, .bus_side_failure, .test_active
);

/* testbench/pt_source_model.sv */
// far-side model: measurement channels seen by the watch
`timescale 1ns/100ps
module pt_source_model (
  // clock and update tick
  input  wire logic   sys_clk,
  input  wire logic   update_pulse,
  // channel magnitudes and angles
  output logic [7:0]  mag_a,
  output logic [7:0]  mag_b,
  output logic [7:0]  mag_c,
  output logic [7:0]  mag_d,
  output logic [11:0] ang_a,
  output logic [11:0] ang_b,
  output logic [11:0] ang_c,
  output logic [11:0] ang_d,
  // sequence magnitudes
  output logic [7:0]  pos_seq,
  output logic [7:0]  neg_seq,
  output logic [7:0]  zero_seq
);
  // levels, angle step and rotation are set by the bench
  logic [3:0][7:0]  lvl  = {4{8'h32}};
  logic [11:0]      step = 12'h000;
  logic [1:0]       seq  = 2'h0;
  logic [3:0][7:0]  m_q  = '0;
  logic [3:0][11:0] a_q  = '0;
  assign {mag_d, mag_c, mag_b, mag_a} = m_q;
  assign {ang_d, ang_c, ang_b, ang_a} = a_q;
  always_ff @(posedge sys_clk) begin
    if (update_pulse) begin
      m_q <= lvl;
      for (int i = 0; i < 4; i++) begin
        a_q[i] <= (a_q[i] + step) % 12'he10;
      end
    end
  end
  assign zero_seq = 8'h00;
  assign pos_seq  = (seq == 2'h0) ? 8'h64 : (seq == 2'h1) ? 8'h0a : 8'h32;
  assign neg_seq  = (seq == 2'h0) ? 8'h0a : (seq == 2'h1) ? 8'h64 : 8'h32;
endmodule

/* testbench/potential_transformer_watch_tb.sv */
// self-checking bench of the potential transformer watch
`timescale 1ns/100ps
module potential_transformer_watch_tb;
  localparam int UPD = 16;
  logic              sys_clk = 1'b0;
  logic              rst, update_pulse, start_q, alarm_q, blocked_q;
  logic [7:0]        mag_a, mag_b, mag_c, mag_d, pos_seq, neg_seq, zero_seq;
  logic [11:0]       ang_a, ang_b, ang_c, ang_d;
  logic              bus_breaker_trip_input, line_breaker_trip_input;
  logic              block_input, settings_load, mode_load, force_load;
  logic [7:0]        low_pickup_set, high_detect_set, lo, hi;
  logic [9:0]        angle_shift_set;
  logic [18:0]       operate_delay_set;
  logic              bus_fuse_check_set, line_fuse_check_set, exp_pick;
  logic              allow_individual_mode, stage_forcing_enable;
  logic [2:0]        mode_set, force_set, node_operating_mode;
  logic [2:0]        status_q, bus_state_q;
  logic              bus_side_failure, line_side_failure, test_active;
  logic [2:0][15:0]  ratio_low_q, ratio_high_q;
  logic [31:0]       seed = 32'h7659;
  int                errors = 0;
  int                cmp_count = 0;
  // phase a, b, c levels and whether they must pick up
  logic [24:0]       pick_tbl [4] = '{{8'h02, 8'h32, 8'h32, 1'b1},
    {8'h32, 8'h32, 8'h32, 1'b0}, {8'h5a, 8'h5a, 8'h32, 1'b1},
    {8'h5a, 8'h32, 8'h32, 1'b0}};

  always #2 sys_clk = ~sys_clk;

  pt_source_model u_src (
    .sys_clk, .update_pulse, .mag_a, .mag_b, .mag_c, .mag_d,
    .ang_a, .ang_b, .ang_c, .ang_d, .pos_seq, .neg_seq, .zero_seq
  );
  potential_transformer_watch #(.UPDATE_CYCLES(UPD)) u_dut (
    .sys_clk, .rst, .mag_a, .mag_b, .mag_c, .mag_d,
    .ang_a, .ang_b, .ang_c, .ang_d, .pos_seq, .neg_seq, .zero_seq,
    .bus_breaker_trip_input, .line_breaker_trip_input, .block_input,
    .settings_load, .low_pickup_set, .high_detect_set, .angle_shift_set,
    .operate_delay_set, .bus_fuse_check_set, .line_fuse_check_set,
    .allow_individual_mode, .mode_load, .mode_set, .stage_forcing_enable,
    .force_load, .force_set, .update_pulse, .node_operating_mode,
    .status_q, .bus_state_q, .start_q, .alarm_q, .blocked_q,
    .bus_side_failure, .line_side_failure, .test_active,
    .ratio_low_q, .ratio_high_q
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ratio(logic [7:0] th, logic [7:0] m);
    return (m == 8'h00) ? 16'hffff : 16'((32'(th) << 8) / 32'(m));
  endfunction
  function automatic logic [7:0] clamp(logic [7:0] v, mn, mx);
    return (v < mn) ? mn : ((v > mx) ? mx : v);
  endfunction
  task automatic ticks(int n);
    repeat (n * UPD) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(logic [7:0] l, h, logic [18:0] d, logic fz);
    low_pickup_set = l;
    high_detect_set = h;
    operate_delay_set = d;
    bus_fuse_check_set = fz;
    line_fuse_check_set = fz;
    settings_load = 1'b1;
    @(posedge sys_clk);
    #1;
    settings_load = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // which 0 loads the mode, 1 the forced status
  task automatic strobe(int which, logic [2:0] v);
    mode_set = v;
    force_set = v;
    mode_load = (which == 0);
    force_load = (which == 1);
    @(posedge sys_clk);
    #1;
    mode_load = 1'b0;
    force_load = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    {bus_breaker_trip_input, line_breaker_trip_input, block_input} = '0;
    {settings_load, mode_load, force_load, stage_forcing_enable} = '0;
    {mode_set, force_set, allow_individual_mode} = '0;
    low_pickup_set = pt_watch_pkg::LOW_RST;
    high_detect_set = pt_watch_pkg::HIGH_RST;
    angle_shift_set = pt_watch_pkg::ASL_RST;
    operate_delay_set = 19'h00014;
    {bus_fuse_check_set, line_fuse_check_set} = 2'h3;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk(node_operating_mode, pt_watch_pkg::MODE_ON);
    chk(status_q, pt_watch_pkg::ST_NORMAL);
    chk(bus_state_q, pt_watch_pkg::BUS_DEAD);
    ticks(12);
    chk(bus_state_q, pt_watch_pkg::BUS_SEQ_OK);
    chk(ratio_low_q[0], ratio(pt_watch_pkg::LOW_RST, 8'h32));
    chk(ratio_high_q[1], ratio(pt_watch_pkg::HIGH_RST, 8'h32));
    for (int s = 1; s < 3; s++) begin
      u_src.seq = 2'(s);
      ticks(3);
      chk(bus_state_q, 16'(s + 1));
    end
    u_src.seq = 2'h0;
    // angles stand still, so levels may be anything without a pick-up
    for (int i = 0; i < 6; i++) begin
      lo = (i == 0) ? 8'h02 : 8'(5 + xs() % 46);
      hi = (i == 0) ? 8'hc8 : 8'(1 + xs() % 110);
      for (int p = 0; p < 3; p++) begin
        u_src.lvl[p] = (i == 1 && p == 0) ? 8'h00 : 8'(1 + xs() % 255);
      end
      load(lo, hi, 19'h00014, 1'b1);
      lo = clamp(lo, pt_watch_pkg::LOW_MIN, pt_watch_pkg::LOW_MAX);
      hi = clamp(hi, pt_watch_pkg::HIGH_MIN, pt_watch_pkg::HIGH_MAX);
      ticks(3);
      for (int p = 0; p < 3; p++) begin
        chk(ratio_low_q[p], ratio(lo, u_src.lvl[p]));
        chk(ratio_high_q[p], ratio(hi, u_src.lvl[p]));
      end
    end
    load(pt_watch_pkg::LOW_RST, pt_watch_pkg::HIGH_RST, 19'h00014, 1'b1);
    u_src.step = 12'h064;
    for (int k = 0; k < 4; k++) begin
      {u_src.lvl[0], u_src.lvl[1], u_src.lvl[2], exp_pick} = pick_tbl[k];
      ticks(4);
      chk(start_q, exp_pick);
      chk(bus_state_q, exp_pick ? 3'h4 : 3'h1);
    end
    u_src.step = 12'h000;
    u_src.lvl[0] = 8'h02;
    ticks(12);
    chk(start_q, 1'b0);
    // a limit past the top is clamped to 90 degrees
    angle_shift_set = 10'h3e8;
    load(pt_watch_pkg::LOW_RST, pt_watch_pkg::HIGH_RST, 19'h00014, 1'b1);
    u_src.step = 12'h064;
    ticks(12);
    chk(start_q, 1'b0);
    u_src.step = 12'h087;
    ticks(12);
    chk(start_q, 1'b1);
    angle_shift_set = pt_watch_pkg::ASL_RST;
    block_input = 1'b1;
    ticks(4);
    chk(blocked_q, 1'b1);
    chk(status_q, pt_watch_pkg::ST_BLOCKED);
    block_input = 1'b0;
    u_src.lvl[0] = 8'h32;
    ticks(4);
    chk(blocked_q, 1'b0);
    for (int f = 1; f >= 0; f--) begin
      load(pt_watch_pkg::LOW_RST, pt_watch_pkg::HIGH_RST, 19'h00014, 1'(f));
      {bus_breaker_trip_input, line_breaker_trip_input} = 2'h3;
      ticks(3);
      chk(bus_side_failure, 16'(f));
      chk(line_side_failure, 16'(f));
      {bus_breaker_trip_input, line_breaker_trip_input} = 2'h0;
      ticks(3);
    end
    load(pt_watch_pkg::LOW_RST, pt_watch_pkg::HIGH_RST, 19'h00003, 1'b1);
    u_src.lvl[0] = 8'h02;
    ticks(9);
    chk(alarm_q, 1'b1);
    chk(status_q, pt_watch_pkg::ST_BUS_FAIL);
    allow_individual_mode = 1'b1;
    for (int m = 0; m < 6; m++) begin
      strobe(0, 3'(m));
      chk(node_operating_mode, m > 4 ? 16'h4 : 16'(m));
      chk(test_active, 16'(m == 2 || m == 3));
    end
    load(pt_watch_pkg::LOW_RST, pt_watch_pkg::HIGH_RST, 19'h00003, 1'b1);
    chk(node_operating_mode, pt_watch_pkg::MODE_OFF);
    ticks(3);
    chk(alarm_q, 1'b0);
    chk(start_q, 1'b0);
    allow_individual_mode = 1'b0;
    strobe(0, 3'h0);
    chk(node_operating_mode, pt_watch_pkg::MODE_ON);
    allow_individual_mode = 1'b1;
    ticks(1);
    chk(node_operating_mode, pt_watch_pkg::MODE_OFF);
    strobe(0, 3'h0);
    stage_forcing_enable = 1'b1;
    for (int f = 0; f < 6; f++) begin
      strobe(1, 3'(f));
      ticks(2);
      chk(status_q, f > 4 ? 16'h4 : 16'(f));
    end
    stage_forcing_enable = 1'b0;
    strobe(1, 3'h1);
    stage_forcing_enable = 1'b1;
    ticks(2);
    chk(status_q, pt_watch_pkg::ST_BLOCKED);
    stage_forcing_enable = 1'b0;
    u_src.lvl = '0;
    ticks(3);
    chk(bus_state_q, pt_watch_pkg::BUS_DEAD);
    end_of_test();
  end
endmodule
